// ===== verilog/tsrm_pkg.sv
// Purpose: shared constants for the temperature sensor register map
// Assumes: 8-bit register addresses, 8-bit data
// Notes: offsets and reset values are named once here
package tsrm_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned TEMP_W = 11;
    localparam int unsigned FRAC_W = 3;
    // ==========================================================
    // register offsets
    localparam logic [7:0] A_INT_TEMP = 8'h00;
    localparam logic [7:0] A_EXT_TEMP = 8'h01;
    localparam logic [7:0] A_STATUS = 8'h02;
    localparam logic [7:0] A_CONFIG = 8'h03;
    localparam logic [7:0] A_RATE = 8'h04;
    localparam logic [7:0] A_INT_HI = 8'h05;
    localparam logic [7:0] A_INT_LO = 8'h06;
    localparam logic [7:0] A_EXT_HI = 8'h07;
    localparam logic [7:0] A_EXT_LO = 8'h08;
    localparam logic [7:0] A_CONFIG_M = 8'h09;
    localparam logic [7:0] A_RATE_M = 8'h0a;
    localparam logic [7:0] A_INT_HI_M = 8'h0b;
    localparam logic [7:0] A_INT_LO_M = 8'h0c;
    localparam logic [7:0] A_EXT_HI_M = 8'h0d;
    localparam logic [7:0] A_EXT_LO_M = 8'h0e;
    localparam logic [7:0] A_ONE_SHOT = 8'h0f;
    localparam logic [7:0] A_EXT_FRAC = 8'h10;
    localparam logic [7:0] A_SCRATCH_A = 8'h11;
    localparam logic [7:0] A_SCRATCH_B = 8'h12;
    localparam logic [7:0] A_EXT_HI_F = 8'h13;
    localparam logic [7:0] A_EXT_LO_F = 8'h14;
    // ==========================================================
    // reset values and the fraction read mask
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h06;
    localparam logic [7:0] RST_HI_LIM = 8'h55;
    localparam logic [7:0] FRAC_MASK = 8'he0;
endpackage

// ===== verilog/tsrm_rw_reg.sv
// Purpose: one host-writable byte reachable at up to two addresses
// Assumes: write strobe is a single-cycle pulse
// Notes: used for every plain and mirrored read-write byte
`timescale 1ns/1ps
module tsrm_rw_reg #(
    parameter logic [7:0] ADDR_A = 8'h00,
    parameter logic [7:0] ADDR_B = 8'h00,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic hit,
    output logic [7:0] value
);
    logic [7:0] val_ff;
    logic [7:0] nxt_val;

    // one storage serves both addresses, so aliases never disagree
    assign hit = (addr == ADDR_A) || (addr == ADDR_B);
    assign nxt_val = (wr_en && hit) ? wdata : val_ff;
    assign value = val_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            val_ff <= RST_VAL;
        end else begin
            val_ff <= nxt_val;
        end
    end
endmodule

// ===== verilog/tsrm_regs.sv
// Purpose: register map of a two-channel temperature sensor
// Assumes: a protocol engine delivers byte reads and writes by address
// Notes: conversion engine lives outside; it feeds results and flags
`timescale 1ns/1ps
module tsrm_regs
    import tsrm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [tsrm_pkg::ADDR_W-1:0] addr,
    input wire logic [tsrm_pkg::DATA_W-1:0] wdata,
    output logic [tsrm_pkg::DATA_W-1:0] rdata,
    input wire logic result_valid,
    input wire logic [tsrm_pkg::TEMP_W-1:0] int_result,
    input wire logic [tsrm_pkg::TEMP_W-1:0] ext_result,
    input wire logic [tsrm_pkg::DATA_W-1:0] status_set,
    input wire logic busy,
    output logic one_shot,
    output logic [tsrm_pkg::DATA_W-1:0] config_value,
    output logic [tsrm_pkg::DATA_W-1:0] rate_value,
    output logic [tsrm_pkg::DATA_W-1:0] int_high_limit,
    output logic [tsrm_pkg::DATA_W-1:0] int_low_limit,
    output logic [tsrm_pkg::TEMP_W-1:0] ext_high_limit,
    output logic [tsrm_pkg::TEMP_W-1:0] ext_low_limit
);
    import tsrm_pkg::*;

    localparam int unsigned NRW = 10;
    localparam int unsigned I_CFG = 0;
    localparam int unsigned I_RATE = 1;
    localparam int unsigned I_IHI = 2;
    localparam int unsigned I_ILO = 3;
    localparam int unsigned I_EHI = 4;
    localparam int unsigned I_ELO = 5;
    localparam int unsigned I_SA = 6;
    localparam int unsigned I_SB = 7;
    localparam int unsigned I_EHF = 8;
    localparam int unsigned I_ELF = 9;
    localparam logic [7:0] ADDR_A_TAB [NRW] = '{A_CONFIG, A_RATE,
        A_INT_HI, A_INT_LO, A_EXT_HI, A_EXT_LO, A_SCRATCH_A,
        A_SCRATCH_B, A_EXT_HI_F, A_EXT_LO_F};
    localparam logic [7:0] ADDR_B_TAB [NRW] = '{A_CONFIG_M, A_RATE_M,
        A_INT_HI_M, A_INT_LO_M, A_EXT_HI_M, A_EXT_LO_M, A_SCRATCH_A,
        A_SCRATCH_B, A_EXT_HI_F, A_EXT_LO_F};
    localparam logic [7:0] RST_TAB [NRW] = '{RST_ZERO, RST_RATE,
        RST_HI_LIM, RST_ZERO, RST_HI_LIM, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO};

    // ==========================================================
    // read-write bytes and their aliases
    logic [NRW-1:0] rw_hit;
    logic [7:0] rw_val [NRW];

    genvar g;
    generate
        for (g = 0; g < NRW; g++) begin : g_rw
            tsrm_rw_reg #(
                .ADDR_A(ADDR_A_TAB[g]),
                .ADDR_B(ADDR_B_TAB[g]),
                .RST_VAL(RST_TAB[g])
            ) u_reg (
                .clk(clk),
                .rstn(rstn),
                .wr_en(wr_en),
                .addr(addr),
                .wdata(wdata),
                .hit(rw_hit[g]),
                .value(rw_val[g])
            );
        end
    endgenerate

    assign config_value = rw_val[I_CFG];
    assign rate_value = rw_val[I_RATE];
    assign int_high_limit = rw_val[I_IHI];
    assign int_low_limit = rw_val[I_ILO];
    // limit comparison uses integer byte plus top fraction bits
    assign ext_high_limit = {rw_val[I_EHI],
        rw_val[I_EHF][DATA_W-1 -: FRAC_W]};
    assign ext_low_limit = {rw_val[I_ELO],
        rw_val[I_ELF][DATA_W-1 -: FRAC_W]};

    // ==========================================================
    // temperature results
    logic [7:0] int_hi_ff;
    logic [7:0] ext_hi_ff;
    logic [FRAC_W-1:0] int_fr_ff;
    logic [FRAC_W-1:0] ext_fr_ff;
    logic [FRAC_W-1:0] ext_shadow_ff;
    logic [FRAC_W-1:0] int_shadow_ff;
    logic [7:0] nxt_int_hi;
    logic [7:0] nxt_ext_hi;
    logic [FRAC_W-1:0] nxt_int_fr;
    logic [FRAC_W-1:0] nxt_ext_fr;

    assign nxt_int_hi = result_valid ?
        int_result[TEMP_W-1 -: DATA_W] : int_hi_ff;
    assign nxt_ext_hi = result_valid ?
        ext_result[TEMP_W-1 -: DATA_W] : ext_hi_ff;
    assign nxt_int_fr = result_valid ? int_result[FRAC_W-1:0] : int_fr_ff;
    assign nxt_ext_fr = result_valid ? ext_result[FRAC_W-1:0] : ext_fr_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            int_hi_ff <= RST_ZERO;
            ext_hi_ff <= RST_ZERO;
            int_fr_ff <= '0;
            ext_fr_ff <= '0;
        end else begin
            int_hi_ff <= nxt_int_hi;
            ext_hi_ff <= nxt_ext_hi;
            int_fr_ff <= nxt_int_fr;
            ext_fr_ff <= nxt_ext_fr;
        end
    end

    // ==========================================================
    // read decode
    logic rd_int_hi;
    logic rd_ext_hi;
    logic rd_status;
    assign rd_int_hi = rd_en && (addr == A_INT_TEMP);
    assign rd_ext_hi = rd_en && (addr == A_EXT_TEMP);
    assign rd_status = rd_en && (addr == A_STATUS);

    // the shadow keeps a pair coherent even if a conversion lands
    // between the high and the low read
    logic [FRAC_W-1:0] nxt_ext_shadow;
    logic [FRAC_W-1:0] nxt_int_shadow;
    assign nxt_ext_shadow = rd_ext_hi ? ext_fr_ff : ext_shadow_ff;
    // internal low byte lives above this range; its shadow is kept
    // but no read path or output port uses it
    assign nxt_int_shadow = rd_int_hi ? int_fr_ff : int_shadow_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_shadow_ff <= '0;
            int_shadow_ff <= '0;
        end else begin
            ext_shadow_ff <= nxt_ext_shadow;
            int_shadow_ff <= nxt_int_shadow;
        end
    end

    // ==========================================================
    // status: hardware set wins over read clear
    logic [7:0] status_ff;
    logic [7:0] nxt_status;
    logic [7:0] status_view;
    // busy is live, not sticky, and is never cleared by reading
    assign status_view = {busy, status_ff[DATA_W-2:0]};
    assign nxt_status = (rd_status ? RST_ZERO : status_ff)
        | {1'b0, status_set[DATA_W-2:0]};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_ff <= RST_ZERO;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // ==========================================================
    // one shot: any data value fires it
    logic one_shot_ff;
    logic nxt_one_shot;
    assign nxt_one_shot = wr_en && (addr == A_ONE_SHOT);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            one_shot_ff <= 1'b0;
        end else begin
            one_shot_ff <= nxt_one_shot;
        end
    end
    assign one_shot = one_shot_ff;

    // ==========================================================
    // read mux; writes to read-only bytes match no storage
    logic [7:0] rw_rdata;
    logic [7:0] ro_rdata;
    logic [7:0] nxt_rdata;
    logic [7:0] rdata_ff;

    always_comb begin
        rw_rdata = RST_ZERO;
        for (int i = 0; i < NRW; i++) begin
            if (rw_hit[i]) begin
                rw_rdata = rw_val[i];
            end
        end
    end

    always_comb begin
        case (addr)
            A_INT_TEMP: ro_rdata = int_hi_ff;
            A_EXT_TEMP: ro_rdata = ext_hi_ff;
            A_STATUS: ro_rdata = status_view;
            A_EXT_FRAC: ro_rdata = {ext_shadow_ff,
                {(DATA_W-FRAC_W){1'b0}}};
            default: ro_rdata = RST_ZERO;
        endcase
    end

    // fraction limit bytes read back only their used top bits
    logic frac_addr;
    assign frac_addr = (addr == A_EXT_HI_F) || (addr == A_EXT_LO_F);
    assign nxt_rdata = !rd_en ? rdata_ff :
        (|rw_hit) ? (frac_addr ? (rw_rdata & FRAC_MASK) : rw_rdata)
                  : ro_rdata;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= RST_ZERO;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign rdata = rdata_ff;
endmodule

// ===== tb/tsrm_regs_sva.sv
// Purpose: port-level assertions for the register map
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every tsrm_regs instance
`timescale 1ns/1ps
module tsrm_regs_chk
    import tsrm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic [7:0] status_set,
    input wire logic one_shot,
    input wire logic [7:0] config_value,
    input wire logic [7:0] rate_value,
    input wire logic [7:0] int_high_limit,
    input wire logic [10:0] ext_high_limit
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // decoded host strobes
    wire os_wr = wr_en && addr == A_ONE_SHOT;
    wire cfg_wr = wr_en && (addr == A_CONFIG || addr == A_CONFIG_M);
    wire rate_wr = wr_en && (addr == A_RATE || addr == A_RATE_M);
    wire ihi_wr = wr_en && (addr == A_INT_HI || addr == A_INT_HI_M);
    sequence s_st_rd;
        rd_en && addr == A_STATUS && status_set == 8'h00;
    endsequence
    property p_one_shot; os_wr |=> one_shot; endproperty
    a_one_shot: assert property (p_one_shot) else $error("no pulse");
    property p_os_cause; one_shot |-> $past(os_wr); endproperty
    a_os_cause: assert property (p_os_cause)
        else $error("stray pulse");
    property p_cfg; cfg_wr |=> config_value == $past(wdata); endproperty
    a_cfg: assert property (p_cfg) else $error("config write lost");
    property p_rate; rate_wr |=> rate_value == $past(wdata); endproperty
    a_rate: assert property (p_rate) else $error("rate write lost");
    property p_ihi; ihi_wr |=> int_high_limit == $past(wdata); endproperty
    a_ihi: assert property (p_ihi) else $error("limit write lost");
    property p_efr;
        wr_en && addr == A_EXT_HI_F |=>
            ext_high_limit[2:0] == $past(wdata[7:5]);
    endproperty
    a_efr: assert property (p_efr) else $error("fraction lost");
    property p_hold; !rd_en |=> $stable(rdata); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
    property p_unmap;
        rd_en && addr > A_EXT_LO_F |=> rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped nonzero");
    property p_rate_rd;
        rd_en && addr == A_RATE_M |=> rdata == $past(rate_value);
    endproperty
    a_rate_rd: assert property (p_rate_rd)
        else $error("rate readback");
    property p_status;
        s_st_rd ##1 status_set == 8'h00 ##1 s_st_rd |=> rdata[6:0] == 7'h00;
    endproperty
    a_status: assert property (p_status) else $error("status kept");
    c_status: cover property (s_st_rd);
    c_one_shot: cover property (os_wr);
    c_unmap: cover property (rd_en && addr > A_EXT_LO_F);
endmodule
bind tsrm_regs tsrm_regs_chk u_tsrm_regs_chk (.clk(clk), .rstn(rstn),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .status_set(status_set), .one_shot(one_shot),
    .config_value(config_value), .rate_value(rate_value),
    .int_high_limit(int_high_limit), .ext_high_limit(ext_high_limit));

// ===== tb/tsrm_host_model.sv
// Purpose: host side issuing single-byte reads and writes
// Assumes: one strobe cycle per byte, read data one cycle later
// Notes: idle address and data show inverted values, never stale ones
`timescale 1ns/1ps
module tsrm_host_model (
    input wire logic clk,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'hff;
        wdata = 8'h00;
    end
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        wr_en <= wr;
        rd_en <= !wr;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
        q = rdata;
    endtask
endmodule

// ===== tb/tb.sv
// Purpose: self-checking bench for the register map
// Assumes: host model issues every register access
// Notes: conversion results and flags are driven here directly
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rstn, wr_en, rd_en, result_valid, busy, one_shot;
    logic [7:0] addr, wdata, rdata, status_set, config_value, rate_value;
    logic [7:0] int_high_limit, int_low_limit;
    logic [10:0] int_result, ext_result, ext_high_limit, ext_low_limit;
    int checks = 0;
    int mismatches = 0;
    always #4 clk = ~clk;
    tsrm_regs u_tsrm_regs (.clk(clk), .rstn(rstn), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
        .result_valid(result_valid), .int_result(int_result),
        .ext_result(ext_result), .status_set(status_set), .busy(busy),
        .one_shot(one_shot), .config_value(config_value),
        .rate_value(rate_value), .int_high_limit(int_high_limit),
        .int_low_limit(int_low_limit), .ext_high_limit(ext_high_limit),
        .ext_low_limit(ext_low_limit));
    tsrm_host_model u_tsrm_host_model (.clk(clk), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata));
    // ==========================================================
    // shared helpers
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_tsrm_host_model.xfer(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_tsrm_host_model.xfer(1'b1, a, d, q);
    endtask
    task automatic pulse_result(input logic [10:0] i,
        input logic [10:0] e);
        @(posedge clk);
        result_valid <= 1'b1;
        int_result <= i;
        ext_result <= e;
        @(posedge clk);
        result_valid <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset_map;
        logic [7:0] e;
        for (int a = 0; a < 23; a++) begin
            e = (a == 4 || a == 10) ? 8'h06 :
                (a == 5 || a == 7 || a == 11 || a == 13) ? 8'h55 : 8'h00;
            if (a != 15) rd(8'(a), e);
        end
    endtask
    task automatic t_read_only;
        logic [7:0] ro [4] = '{8'h00, 8'h01, 8'h02, 8'h10};
        for (int i = 0; i < 4; i++) begin
            wr(ro[i], 8'hff);
            rd(ro[i], 8'h00);
        end
    endtask
    task automatic t_alias;
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            d = 8'ha1 + 8'(i);
            wr(8'(9 + i), d);
            rd(8'(3 + i), d);
            wr(8'(3 + i), ~d);
            rd(8'(9 + i), ~d);
        end
        chk(config_value, 8'h5e);
        chk(rate_value, 8'h5d);
        chk(int_low_limit, 8'h5b);
    endtask
    task automatic t_frac_scratch;
        wr(8'h11, 8'h3c);
        wr(8'h12, 8'hc3);
        wr(8'h13, 8'hff);
        wr(8'h14, 8'h5f);
        rd(8'h11, 8'h3c);
        rd(8'h12, 8'hc3);
        rd(8'h13, 8'he0);
        rd(8'h14, 8'h40);
        chk(ext_high_limit[10:3], 8'h5a);
        chk({5'h00, ext_high_limit[2:0]}, 8'h07);
        chk({5'h00, ext_low_limit[2:0]}, 8'h02);
        chk(ext_low_limit[10:3], 8'h59);
        chk(int_high_limit, 8'h5c);
    endtask
    task automatic t_result;
        pulse_result(11'h5a3, 11'h2c5);
        rd(8'h00, 8'hb4);
        rd(8'h01, 8'h58);
        pulse_result(11'h5a3, 11'h3ff);
        rd(8'h10, 8'ha0);
        rd(8'h01, 8'h7f);
        rd(8'h10, 8'he0);
    endtask
    task automatic t_status;
        @(posedge clk);
        status_set <= 8'hff;
        busy <= 1'b1;
        @(posedge clk);
        status_set <= 8'h00;
        rd(8'h02, 8'hff);
        rd(8'h02, 8'h80);
        @(posedge clk);
        busy <= 1'b0;
        rd(8'h02, 8'h00);
        // a set landing on the clearing read must survive it
        @(posedge clk);
        status_set <= 8'h01;
        rd(8'h02, 8'h01);
        @(posedge clk);
        status_set <= 8'h00;
        rd(8'h02, 8'h01);
        rd(8'h02, 8'h00);
    endtask
    task automatic t_one_shot;
        wr(8'h0f, 8'h00);
        chk({7'h00, one_shot}, 8'h01);
        @(posedge clk);
        #1;
        chk({7'h00, one_shot}, 8'h00);
        wr(8'h0f, 8'ha5);
        chk({7'h00, one_shot}, 8'h01);
    endtask
    task automatic t_mid_reset;
        wr(8'h03, 8'h3c);
        rd(8'h03, 8'h3c);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk(config_value, 8'h00);
        chk(rdata, 8'h00);
        chk({7'h00, one_shot}, 8'h00);
        rd(8'h04, 8'h06);
        rd(8'h09, 8'h00);
    endtask
    initial begin
        rstn = 1'b0;
        result_valid = 1'b0;
        int_result = 11'h000;
        ext_result = 11'h000;
        status_set = 8'h00;
        busy = 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_reset_map();
        t_read_only();
        t_alias();
        t_frac_scratch();
        t_result();
        t_status();
        t_one_shot();
        t_mid_reset();
        print_verdict();
    end
    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
endmodule
